// ===== dv/sm_monitor.sv
// Checker on the bus and output pin of the signal modulator
`timescale 1ns/1ps
`default_nettype none
module sm_monitor (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic mod_out_o
);
  logic en, oinv, sw, oe;
  logic [4:0] msel;
  logic wr;
  assign wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  // Shadow fields change only at the acking edge, as in the design
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {en, oinv, sw, oe, msel} <= 9'h020;
    end else if (wr && wb_adr_i == sm_pkg::REG_CTRL_A) begin
      {en, oinv, sw} <= {wb_dat_i[7], wb_dat_i[4], wb_dat_i[0]};
    end else if (wr && wb_adr_i == sm_pkg::REG_OUT_CTRL) begin
      oe <= wb_dat_i[0];
    end else if (wr && wb_adr_i == sm_pkg::REG_MOD_SRC) begin
      msel <= wb_dat_i[4:0];
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_idle_level: assert property (!en && oe |-> mod_out_o == oinv)
    else $error("idle level wrong");
  a_pin_low: assert property (!oe |-> !mod_out_o)
    else $error("disabled pin not low");
  a_src_kept: assert property (wb_ack_o && !wb_we_i && wb_adr_i == sm_pkg::REG_MOD_SRC |-> wb_dat_o == {27'h0, msel})
    else $error("source field readback wrong");
  a_ctrl_kept: assert property (wb_ack_o && !wb_we_i && wb_adr_i == sm_pkg::REG_CTRL_A
    |-> {wb_dat_o[7], wb_dat_o[4], wb_dat_o[0]} == {en, oinv, sw}) else $error("control readback wrong");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : sm_monitor
bind sm_top sm_monitor u_mon (.mclk_i(mclk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .mod_out_o(mod_out_o));
`default_nettype wire

// ===== dv/sm_src_model.sv
// Stand-in for the peripherals and pins that feed the modulator
`timescale 1ns/1ps
`default_nettype none
module sm_src_model (
  input wire logic [4:0] mc_i,
  input wire logic [3:0] hc_i,
  input wire logic [3:0] lc_i,
  input wire logic mv_i,
  input wire logic hv_i,
  input wire logic lv_i,
  output var sm_pkg::sm_src_t src_o
);
  // Unselected sources carry the opposite level, except carrier peripherals picked by neither carrier, which carry the opposite of hv_i
  always_comb begin
    src_o.mod_pin = (mc_i == 5'h00) ? mv_i : !mv_i;
    src_o.carrier_high_signal_pin = (hc_i == 4'h0) ? hv_i : !hv_i;
    src_o.carrier_low_signal_pin = (lc_i == 4'h0) ? lv_i : !lv_i;
    for (int k = 0; k < sm_pkg::MOD_PERIPH_N; k++) begin
      src_o.mod_periph[k] = (mc_i == 5'(k + 2)) ? mv_i : !mv_i;
    end
    for (int k = 0; k < sm_pkg::CAR_PERIPH_N; k++) begin
      src_o.car_periph[k] = (hc_i == 4'(k + 1)) ? hv_i : (lc_i == 4'(k + 1)) ? lv_i : !hv_i;
    end
  end
endmodule : sm_src_model
`default_nettype wire

// ===== dv/sm_top_tb_top.sv
// Register and mixing tests for the signal modulator
`timescale 1ns/1ps
`default_nettype none
module sm_top_tb_top;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] rdat, q;
  logic ack, mout;
  logic mv = 1'b0;
  logic hv = 1'b0;
  logic lv = 1'b0;
  logic [4:0] mc = 5'h00;
  logic [3:0] hc = 4'h0;
  logic [3:0] lc = 4'h0;
  sm_pkg::sm_src_t src;
  int n_mismatch = 0;
  int total_checks = 0;
  always #2.5 mclk_i = !mclk_i;
  sm_top dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .src_i(src), .mod_out_o(mout));
  sm_src_model u_src (.mc_i(mc), .hc_i(hc), .lc_i(lc), .mv_i(mv), .hv_i(hv), .lv_i(lv), .src_o(src));
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Holds the request until ack is seen high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Right after the edge, ack and read data still show their pre-edge values
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask : wb
  task automatic mix(input logic m, input logic h, input logic l, input logic e);
    @(posedge mclk_i);
    mv <= m;
    hv <= h;
    lv <= l;
    @(negedge mclk_i);
    chk("mod_out", {31'h0, mout}, {31'h0, e});
  endtask : mix
  initial begin
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wb(0, 8'(i * 4), 32'h0);
      chk("reset value", q, (i == 5) ? 32'h1 : 32'h0);
    end
    wb(1, 8'h20, 32'hFF);
    wb(0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    mix(1, 1, 1, 1'b0);
    wb(1, 8'h00, 32'h11);
    mix(1, 1, 1, 1'b1);
    wb(1, 8'h14, 32'h0);
    mix(1, 1, 1, 1'b0);
    wb(1, 8'h14, 32'h1);
    wb(1, 8'h08, 32'h1);
    wb(1, 8'h0C, 32'h1);
    wb(1, 8'h10, 32'h2);
    mc <= 5'h01;
    hc <= 4'h1;
    lc <= 4'h2;
    wb(1, 8'h00, 32'h81);
    mix(0, 1, 0, 1'b1);
    mix(0, 0, 1, 1'b0);
    wb(1, 8'h00, 32'h80);
    mix(0, 0, 1, 1'b1);
    wb(1, 8'h04, 32'h22);
    mix(0, 1, 0, 1'b1);
    wb(1, 8'h04, 32'h0);
    wb(1, 8'h00, 32'h90);
    mix(0, 0, 1, 1'b0);
    wb(1, 8'h00, 32'h80);
    for (int k = 0; k < 20; k++) begin
      if (k != 1) begin
        wb(1, 8'h08, 32'(k));
        mc <= 5'(k);
        mix(1, 1, 0, 1'b1);
        mix(0, 1, 0, 1'b0);
      end
    end
    wb(1, 8'h08, 32'h1);
    wb(1, 8'h10, 32'h0);
    lc <= 4'h0;
    wb(1, 8'h00, 32'h81);
    for (int k = 0; k < 16; k++) begin
      wb(1, 8'h0C, 32'(k));
      hc <= 4'(k);
      mix(0, 1, 0, 1'b1);
      mix(0, 0, 1, 1'b0);
    end
    wb(1, 8'h00, 32'h01);
    mix(0, 1, 0, 1'b0);
    wb(0, 8'h08, 32'h0);
    chk("kept source", q, 32'h1);
    wb(1, 8'h00, 32'h81);
    mix(0, 1, 0, 1'b1);
    // Modulator from its pin so that it can change between edges of the carrier
    wb(1, 8'h08, 32'h0);
    mc <= 5'h00;
    wb(1, 8'h00, 32'h80);
    wb(1, 8'h04, 32'h10);
    mix(1, 1, 0, 1'b1);
    mix(0, 1, 0, 1'b1);
    mix(0, 0, 0, 1'b0);
    mix(0, 1, 0, 1'b0);
    wb(1, 8'h04, 32'h01);
    mix(0, 0, 1, 1'b1);
    mix(1, 0, 1, 1'b1);
    mix(1, 0, 0, 1'b0);
    mix(1, 1, 0, 1'b1);
    wb(1, 8'h04, 32'h0);
    mix(0, 1, 0, 1'b0);
    mix(1, 1, 0, 1'b1);
    repeat (4) @(posedge mclk_i);
    wb(0, 8'h00, 32'h0);
    chk("status", {31'h0, q[5]}, 32'h1);
    // Mid-run reset while enabled and the pin is high
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    @(negedge mclk_i);
    chk("pin in reset", {31'h0, mout}, 32'h0);
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    wb(0, 8'h00, 32'h0);
    chk("control after reset", q, 32'h0);
    sel <= 4'hE;
    wb(1, 8'h0C, 32'h3);
    sel <= 4'hF;
    wb(0, 8'h0C, 32'h0);
    chk("lane 0 off write", q, 32'h0);
    results();
  end
endmodule : sm_top_tb_top
`default_nettype wire

// ===== verilog/sm_carrier_sync.sv
// Active-carrier chooser that lets a synchronised carrier pulse finish before switching
`timescale 1ns/1ps
`default_nettype none
module sm_carrier_sync (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic mod_i,
  input wire logic carrier_high_signal_i,
  input wire logic carrier_low_signal_i,
  input wire logic carrier_high_signal_sync_i,
  input wire logic carrier_low_signal_sync_i,
  output logic use_high_o
);

  sm_pkg::sm_sync_state_t st;
  sm_pkg::sm_sync_state_t next_st;
  logic outgoing_busy;

  // Old carrier is held only while it is synchronised and still high
  always_comb begin
    outgoing_busy = st.active_high ? (carrier_high_signal_sync_i && carrier_high_signal_i) : (carrier_low_signal_sync_i && carrier_low_signal_i);
    if ((mod_i != st.active_high) && outgoing_busy) begin
      use_high_o = st.active_high;
    end else begin
      use_high_o = mod_i;
    end
    next_st.active_high = use_high_o;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : sm_carrier_sync
`default_nettype wire

// ===== verilog/sm_pkg.sv
// Package with register map, field layout, source codes and carriers for the signal modulator
package sm_pkg;

  localparam int WB_ADR_W = 8;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL_A = 8'h00;
  localparam logic [7:0] REG_CTRL_B = 8'h04;
  localparam logic [7:0] REG_MOD_SRC = 8'h08;
  localparam logic [7:0] REG_CARRIER_HIGH_SIGNAL_SEL = 8'h0C;
  localparam logic [7:0] REG_CARRIER_LOW_SIGNAL_SEL = 8'h10;
  localparam logic [7:0] REG_OUT_CTRL = 8'h14;

  // modulator_control_reg_a fields
  localparam int CTRL_A_EN_BIT = 7;
  localparam int CTRL_A_STAT_BIT = 5;
  localparam int CTRL_A_OINV_BIT = 4;
  localparam int CTRL_A_SWBIT_BIT = 0;

  // modulator_control_reg_b fields
  localparam int CTRL_B_CHINV_BIT = 5;
  localparam int CTRL_B_CHSYNC_BIT = 4;
  localparam int CTRL_B_CLINV_BIT = 1;
  localparam int CTRL_B_CLSYNC_BIT = 0;

  localparam int OUT_CTRL_OE_BIT = 0;

  localparam int MOD_SEL_W = 5;
  localparam int CAR_SEL_W = 4;
  localparam int MOD_PERIPH_N = 18;
  localparam int CAR_PERIPH_N = 15;

  // Modulator source codes; codes 2..19 pick peripheral inputs 0..17
  localparam logic [4:0] MOD_SRC_PIN = 5'h00;
  localparam logic [4:0] MOD_SRC_SWBIT = 5'h01;
  localparam logic [4:0] MOD_SRC_PERIPH0 = 5'h02;
  localparam logic [4:0] MOD_SRC_LAST = 5'h13;

  // Carrier source codes; codes 1..15 pick peripheral inputs 0..14
  localparam logic [3:0] CAR_SRC_PIN = 4'h0;
  localparam logic [3:0] CAR_SRC_PERIPH0 = 4'h1;

  // Reset values
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_BIT = 1'b0;
  localparam logic RST_OUT_EN = 1'b1;
  localparam logic [4:0] RST_MOD_SEL = 5'h00;
  localparam logic [3:0] RST_CAR_SEL = 4'h0;

  typedef struct packed {
    logic mod_pin;
    logic carrier_high_signal_pin;
    logic carrier_low_signal_pin;
    logic [MOD_PERIPH_N-1:0] mod_periph;
    logic [CAR_PERIPH_N-1:0] car_periph;
  } sm_src_t;

  typedef struct packed {
    logic enable;
    logic out_inv;
    logic sw_bit;
    logic carrier_high_signal_inv;
    logic carrier_high_signal_sync;
    logic carrier_low_signal_inv;
    logic carrier_low_signal_sync;
    logic out_en;
    logic [MOD_SEL_W-1:0] mod_sel;
    logic [CAR_SEL_W-1:0] carrier_high_signal_sel;
    logic [CAR_SEL_W-1:0] carrier_low_signal_sel;
  } sm_cfg_t;

  typedef struct packed {
    logic active_high;
  } sm_sync_state_t;

  typedef struct packed {
    sm_cfg_t cfg;
    logic ack;
    logic [WB_DAT_W-1:0] dat;
    logic stat_meta;
    logic stat_sync;
  } sm_state_t;

endpackage : sm_pkg

// ===== verilog/sm_top.sv
// Signal modulator: source selection, carrier mixing, output polarity and Wishbone registers
//
// Behaviour
// - Output is the active carrier picked by the modulator, driven to the pin.
// - Modulator high selects the high carrier, modulator low the low carrier.
// - Modulator and both carriers each selectable from a peripheral or a pin.
// - Setting the enable bit turns the modulator on.
// - With enable clear, both carriers are forced to ground.
// - With enable clear, the modulator comes from the software bit.
// - Disabling keeps source selections; they apply again when re-enabled.
// - Output disable keeps mixing but holds the pin low.
// - Five-bit field picks one of twenty modulator sources.
// - Two four-bit fields pick the high and low carrier sources.
// - Synchronised carrier finishes its pulse before the switch to the other carrier.
// - Separate sync enables for high and low carriers in control register b.
// - Separate polarity bits invert the selected high and low carriers.
// - Software bit supplies the modulator value when selected.
// - Output polarity bit inverts the value driven to the pin.
// - Mixing keeps running in sleep whenever its sources run.
// - Reset disables the modulator and restores all registers to defaults.
// - Output idles high when inverted, low otherwise.
// - Read-only status bit reports the output value through a two-flop synchroniser.
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module sm_top (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sm_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [sm_pkg::WB_SEL_W-1:0] wb_sel_i,
  input wire logic [sm_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic [sm_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire sm_pkg::sm_src_t src_i,
  output logic mod_out_o
);

  sm_pkg::sm_state_t st;
  sm_pkg::sm_state_t next_st;

  logic mod_sel_val;
  logic carrier_high_signal_sel_val;
  logic carrier_low_signal_sel_val;
  logic mod_sig;
  logic carrier_high_signal_sig;
  logic carrier_low_signal_sig;
  logic use_high;
  logic mix;
  logic bus_req;

  // Modulator source decode; unused codes read as low
  function automatic logic mod_pick(
    input logic [sm_pkg::MOD_SEL_W-1:0] sel,
    input sm_pkg::sm_src_t s,
    input logic sw_bit
  );
    logic [sm_pkg::MOD_SEL_W-1:0] idx;
    mod_pick = 1'b0;
    idx = sel - sm_pkg::MOD_SRC_PERIPH0;
    if (sel == sm_pkg::MOD_SRC_PIN) begin
      mod_pick = s.mod_pin;
    end else if (sel == sm_pkg::MOD_SRC_SWBIT) begin
      mod_pick = sw_bit;
    end else if (sel <= sm_pkg::MOD_SRC_LAST) begin
      mod_pick = s.mod_periph[idx];
    end
  endfunction : mod_pick

  // Carrier source decode, shared by both carriers
  function automatic logic car_pick(
    input logic [sm_pkg::CAR_SEL_W-1:0] sel,
    input logic pin,
    input logic [sm_pkg::CAR_PERIPH_N-1:0] periph
  );
    logic [sm_pkg::CAR_SEL_W-1:0] idx;
    idx = sel - sm_pkg::CAR_SRC_PERIPH0;
    if (sel == sm_pkg::CAR_SRC_PIN) begin
      car_pick = pin;
    end else begin
      car_pick = periph[idx];
    end
  endfunction : car_pick

  function automatic logic [sm_pkg::WB_DAT_W-1:0] reg_read(
    input sm_pkg::sm_cfg_t c,
    input logic stat,
    input logic [sm_pkg::WB_ADR_W-1:0] adr
  );
    reg_read = '0;
    case (adr)
      sm_pkg::REG_CTRL_A: begin
        reg_read[sm_pkg::CTRL_A_EN_BIT] = c.enable;
        reg_read[sm_pkg::CTRL_A_STAT_BIT] = stat;
        reg_read[sm_pkg::CTRL_A_OINV_BIT] = c.out_inv;
        reg_read[sm_pkg::CTRL_A_SWBIT_BIT] = c.sw_bit;
      end
      sm_pkg::REG_CTRL_B: begin
        reg_read[sm_pkg::CTRL_B_CHINV_BIT] = c.carrier_high_signal_inv;
        reg_read[sm_pkg::CTRL_B_CHSYNC_BIT] = c.carrier_high_signal_sync;
        reg_read[sm_pkg::CTRL_B_CLINV_BIT] = c.carrier_low_signal_inv;
        reg_read[sm_pkg::CTRL_B_CLSYNC_BIT] = c.carrier_low_signal_sync;
      end
      sm_pkg::REG_MOD_SRC: begin
        reg_read[sm_pkg::MOD_SEL_W-1:0] = c.mod_sel;
      end
      sm_pkg::REG_CARRIER_HIGH_SIGNAL_SEL: begin
        reg_read[sm_pkg::CAR_SEL_W-1:0] = c.carrier_high_signal_sel;
      end
      sm_pkg::REG_CARRIER_LOW_SIGNAL_SEL: begin
        reg_read[sm_pkg::CAR_SEL_W-1:0] = c.carrier_low_signal_sel;
      end
      sm_pkg::REG_OUT_CTRL: begin
        reg_read[sm_pkg::OUT_CTRL_OE_BIT] = c.out_en;
      end
      default: begin
        reg_read = '0;
      end
    endcase
  endfunction : reg_read

  // Only byte lane 0 carries fields; other lanes are ignored
  function automatic sm_pkg::sm_cfg_t reg_write(
    input sm_pkg::sm_cfg_t c,
    input logic [sm_pkg::WB_ADR_W-1:0] adr,
    input logic [7:0] d
  );
    reg_write = c;
    case (adr)
      sm_pkg::REG_CTRL_A: begin
        reg_write.enable = d[sm_pkg::CTRL_A_EN_BIT];
        reg_write.out_inv = d[sm_pkg::CTRL_A_OINV_BIT];
        reg_write.sw_bit = d[sm_pkg::CTRL_A_SWBIT_BIT];
      end
      sm_pkg::REG_CTRL_B: begin
        reg_write.carrier_high_signal_inv = d[sm_pkg::CTRL_B_CHINV_BIT];
        reg_write.carrier_high_signal_sync = d[sm_pkg::CTRL_B_CHSYNC_BIT];
        reg_write.carrier_low_signal_inv = d[sm_pkg::CTRL_B_CLINV_BIT];
        reg_write.carrier_low_signal_sync = d[sm_pkg::CTRL_B_CLSYNC_BIT];
      end
      sm_pkg::REG_MOD_SRC: begin
        reg_write.mod_sel = d[sm_pkg::MOD_SEL_W-1:0];
      end
      sm_pkg::REG_CARRIER_HIGH_SIGNAL_SEL: begin
        reg_write.carrier_high_signal_sel = d[sm_pkg::CAR_SEL_W-1:0];
      end
      sm_pkg::REG_CARRIER_LOW_SIGNAL_SEL: begin
        reg_write.carrier_low_signal_sel = d[sm_pkg::CAR_SEL_W-1:0];
      end
      sm_pkg::REG_OUT_CTRL: begin
        reg_write.out_en = d[sm_pkg::OUT_CTRL_OE_BIT];
      end
      default: begin
        reg_write = c;
      end
    endcase
  endfunction : reg_write

  // Source selection; no clocked stage so fast carriers pass intact
  always_comb begin
    mod_sel_val = mod_pick(st.cfg.mod_sel, src_i, st.cfg.sw_bit);
    carrier_high_signal_sel_val = car_pick(st.cfg.carrier_high_signal_sel, src_i.carrier_high_signal_pin, src_i.car_periph) ^ st.cfg.carrier_high_signal_inv;
    carrier_low_signal_sel_val = car_pick(st.cfg.carrier_low_signal_sel, src_i.carrier_low_signal_pin, src_i.car_periph) ^ st.cfg.carrier_low_signal_inv;
    if (st.cfg.enable) begin
      mod_sig = mod_sel_val;
      carrier_high_signal_sig = carrier_high_signal_sel_val;
      carrier_low_signal_sig = carrier_low_signal_sel_val;
    end else begin
      // Selections stay stored; only the signals are overridden
      mod_sig = st.cfg.sw_bit;
      carrier_high_signal_sig = 1'b0;
      carrier_low_signal_sig = 1'b0;
    end
  end

  sm_carrier_sync u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .mod_i(mod_sig),
    .carrier_high_signal_i(carrier_high_signal_sig),
    .carrier_low_signal_i(carrier_low_signal_sig),
    .carrier_high_signal_sync_i(st.cfg.carrier_high_signal_sync),
    .carrier_low_signal_sync_i(st.cfg.carrier_low_signal_sync),
    .use_high_o(use_high)
  );

  // Carrier gated by the modulator level it belongs to
  always_comb begin
    mix = (use_high & carrier_high_signal_sig) | (~use_high & carrier_low_signal_sig);
  end

  // Pin is combinational by design; no sleep gating anywhere
  always_comb begin
    if (st.cfg.out_en) begin
      mod_out_o = mix ^ st.cfg.out_inv;
    end else begin
      mod_out_o = 1'b0;
    end
  end

  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;

  // Status bit may lag or miss edges of fast signals
  always_comb begin
    next_st = st;
    next_st.stat_meta = mod_out_o;
    next_st.stat_sync = st.stat_meta;
    next_st.ack = 1'b0;
    if (bus_req && !st.ack) begin
      next_st.ack = 1'b1;
      next_st.dat = reg_read(st.cfg, st.stat_sync, wb_adr_i);
    end
    // Write lands at the edge where the master sees ack
    if (bus_req && st.ack && wb_we_i && wb_sel_i[0]) begin
      next_st.cfg = reg_write(st.cfg, wb_adr_i, wb_dat_i[7:0]);
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st.cfg.enable <= sm_pkg::RST_ENABLE;
      st.cfg.out_inv <= sm_pkg::RST_BIT;
      st.cfg.sw_bit <= sm_pkg::RST_BIT;
      st.cfg.carrier_high_signal_inv <= sm_pkg::RST_BIT;
      st.cfg.carrier_high_signal_sync <= sm_pkg::RST_BIT;
      st.cfg.carrier_low_signal_inv <= sm_pkg::RST_BIT;
      st.cfg.carrier_low_signal_sync <= sm_pkg::RST_BIT;
      st.cfg.out_en <= sm_pkg::RST_OUT_EN;
      st.cfg.mod_sel <= sm_pkg::RST_MOD_SEL;
      st.cfg.carrier_high_signal_sel <= sm_pkg::RST_CAR_SEL;
      st.cfg.carrier_low_signal_sel <= sm_pkg::RST_CAR_SEL;
      st.ack <= 1'b0;
      st.dat <= '0;
      st.stat_meta <= 1'b0;
      st.stat_sync <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

endmodule : sm_top
`default_nettype wire
